// file: hw/gdpm_regs.svh
// Purpose: Constants for the gate driver protection monitor
// Assumes: 40 MHz clock, 25 ns period
`ifndef GDPM_REGS_SVH
`define GDPM_REGS_SVH
`define GDPM_CLK_PERIOD_NS   25
`define GDPM_GLITCH_NS       50
`define GDPM_GLITCH_CYC      ((`GDPM_GLITCH_NS + `GDPM_CLK_PERIOD_NS - 1) / `GDPM_CLK_PERIOD_NS)
`define GDPM_DEAD_MIN_CYC    8
`define GDPM_DEAD_STEP_CYC   8
`define GDPM_BLANK_CYC       16
`define GDPM_OSC_DIV         4
`define GDPM_TEMP_THRESH     8'hc8
`define GDPM_CNT_MAX         8'hff
`endif

// file: hw/gdpm_pkg.sv
// Purpose: Types for the gate driver protection monitor
// Assumes: Nothing
// Notes:   Phase of one switching sequence
package gdpm_pkg;
    typedef enum logic [1:0] {
        GDPM_IDLE = 2'b00,
        GDPM_RUN  = 2'b01,
        GDPM_DONE = 2'b10
    } gdpm_phase_t;
endpackage : gdpm_pkg

// file: hw/gdpm_tmr_if.sv
// Purpose: Control and result of one gate timer
// Assumes: Single clock
// Notes:   Shared by turn-on and turn-off timers
`timescale 1ns/100ps
`default_nettype none
interface gdpm_tmr_if;
    logic       start;
    logic       reached;
    logic       tick;
    logic       ovf;
    logic       stop;
    logic [7:0] count;
    modport owner (output start, output reached, output tick,
                   input ovf, input stop, input count);
    modport timer (input start, input reached, input tick,
                   output ovf, output stop, output count);
endinterface : gdpm_tmr_if
`default_nettype wire

// file: hw/gdpm_gate_timer.sv
// Purpose: 8-bit gate waveform timer on the secondary oscillator tick
// Assumes: start is a single-cycle pulse; reached may be a held level
// Notes:   ovf pulses once when the count passes ff
`timescale 1ns/100ps
`default_nettype none
`include "gdpm_regs.svh"
module gdpm_gate_timer
(
    input  wire logic    i_clk,
    input  wire logic    i_rst_n,
    gdpm_tmr_if.timer    tmr
);
    gdpm_pkg::gdpm_phase_t phase_q;
    logic [7:0]            cnt_q;
    logic                  ovf_q;
    logic                  stop_q;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            phase_q <= gdpm_pkg::GDPM_IDLE;
            cnt_q   <= 8'h00;
            ovf_q   <= 1'b0;
            stop_q  <= 1'b0;
        end
        else
        begin
            ovf_q  <= 1'b0;
            stop_q <= 1'b0;
            if (tmr.start)
            begin
                phase_q <= gdpm_pkg::GDPM_RUN;
                cnt_q   <= 8'h00;
            end
            else
            begin
                unique case (phase_q)
                    gdpm_pkg::GDPM_IDLE: ;
                    gdpm_pkg::GDPM_RUN:
                    begin
                        if (tmr.reached)
                        begin
                            phase_q <= gdpm_pkg::GDPM_DONE;
                            stop_q  <= 1'b1;
                        end
                        else if (tmr.tick)
                        begin
                            if (cnt_q == `GDPM_CNT_MAX)
                            begin
                                ovf_q   <= 1'b1;
                                phase_q <= gdpm_pkg::GDPM_DONE;
                            end
                            else
                                cnt_q <= cnt_q + 8'h01;
                        end
                    end
                    gdpm_pkg::GDPM_DONE: ;
                    default: phase_q <= gdpm_pkg::GDPM_IDLE;
                endcase
            end
        end
    end

    assign tmr.ovf   = ovf_q;
    assign tmr.stop  = stop_q;
    assign tmr.count = cnt_q;

    // Overflow only after a full count
    a_ovf_at_max: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) ovf_q |-> $past(cnt_q) == 8'hff)
        else $error("timer overflow before ff");
endmodule : gdpm_gate_timer
`default_nettype wire

// file: hw/gdpm_top.sv
// Purpose: Category-C protection logic of a gate driver
// Assumes: One 40 MHz clock; pins pass a three-stage synchroniser
// Notes:   Flags clear by a one-cycle software clear pulse; set wins
`timescale 1ns/100ps
`default_nettype none
`include "gdpm_regs.svh"
module gdpm_top
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_resetn,
    input  wire logic       i_pwm_command_pin,
    input  wire logic       i_counterpart_pwm_input,
    input  wire logic [3:0] i_dead_time_config,
    input  wire logic       i_gate_above_upper,
    input  wire logic       i_gate_below_lower,
    input  wire logic       i_hard_turnoff,
    input  wire logic       i_verification_mode,
    input  wire logic       i_weak_on_mode,
    input  wire logic       i_timing_capture_trigger,
    input  wire logic [7:0] i_temperature,
    input  wire logic       i_spi_invalid,
    input  wire logic       i_spi_parity_bad,
    input  wire logic       i_parity_check_en,
    input  wire logic       i_secondary_uv,
    input  wire logic       i_digital_supply_ok,
    input  wire logic       i_saturation_sense_pin,
    input  wire logic       i_primary_state_output_enable,
    input  wire logic       i_secondary_state_monitor_enable,
    input  wire logic [4:0] i_flag_clear,
    output logic            o_pwm_to_gate,
    output logic            o_crossconduction_status_bit,
    output logic            o_crossconduction_error_flag,
    output logic            o_gate_error_flag,
    output logic            o_overtemperature_flag,
    output logic            o_spi_error_flag,
    output logic            o_turnon_capture_armed,
    output logic            o_turnoff_capture_armed,
    output logic [7:0]      o_turnon_capture_value,
    output logic [7:0]      o_turnoff_capture_value,
    output logic            o_undervoltage_notify_out,
    output logic            o_undervoltage_notify_oe,
    output logic            o_state_report_out,
    output logic            o_state_report_oe,
    output logic            o_state_report_level_bit
);
    logic [1:0] rst_sync_q;
    logic       rst_n;
    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            rst_sync_q <= 2'b00;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // Three-stage synchronisers for pins
    logic [2:0] cmd_s_q, cp_s_q, up_s_q, lo_s_q, sat_s_q;
    logic       cmd_q, cp_q, up_q, lo_q, sat_q;
    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd_s_q <= 3'h0;
            cp_s_q  <= 3'h0;
            up_s_q  <= 3'h0;
            lo_s_q  <= 3'h0;
            sat_s_q <= 3'h0;
            cmd_q   <= 1'b0;
            cp_q    <= 1'b0;
            up_q    <= 1'b0;
            lo_q    <= 1'b0;
            sat_q   <= 1'b0;
        end
        else
        begin
            cmd_s_q <= {cmd_s_q[1:0], i_pwm_command_pin};
            cp_s_q  <= {cp_s_q[1:0], i_counterpart_pwm_input};
            up_s_q  <= {up_s_q[1:0], i_gate_above_upper};
            lo_s_q  <= {lo_s_q[1:0], i_gate_below_lower};
            sat_s_q <= {sat_s_q[1:0], i_saturation_sense_pin};
            if (cmd_s_q[2] == cmd_s_q[1]) cmd_q <= cmd_s_q[2];
            if (cp_s_q[2] == cp_s_q[1])   cp_q  <= cp_s_q[2];
            if (up_s_q[2] == up_s_q[1])   up_q  <= up_s_q[2];
            if (lo_s_q[2] == lo_s_q[1])   lo_q  <= lo_s_q[2];
            if (sat_s_q[2] == sat_s_q[1]) sat_q <= sat_s_q[2];
        end
    end

    // Dead time after the counterpart releases
    logic [7:0] dead_q;
    logic [7:0] dead_load;
    logic       inhibit;
    assign dead_load = 8'(`GDPM_DEAD_MIN_CYC)
                     + 8'(i_dead_time_config) * 8'(`GDPM_DEAD_STEP_CYC);
    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            dead_q <= 8'h00;
        else if (cp_q)
            dead_q <= dead_load;
        else if (dead_q != 8'h00)
            dead_q <= dead_q - 8'h01;
    end
    // inhibit only from counterpart input, no disable
    assign inhibit = cp_q || (dead_q != 8'h00);

    logic pwm_q;
    logic blocked_q;
    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pwm_q     <= 1'b0;
            blocked_q <= 1'b0;
        end
        else if (!cmd_q)
        begin
            pwm_q     <= 1'b0;
            blocked_q <= 1'b0;
        end
        else if (inhibit && !pwm_q)
            blocked_q <= 1'b1;
        else if (!blocked_q)
            pwm_q <= 1'b1;
    end
    assign o_pwm_to_gate = pwm_q;

    logic conflict;
    assign conflict = cmd_q && inhibit && !pwm_q;
    assign o_crossconduction_status_bit = conflict;

    localparam logic [3:0] GLITCH_CYC = 4'(`GDPM_GLITCH_CYC);
    logic [3:0] glitch_q;
    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            glitch_q <= 4'h0;
        else if (!conflict)
            glitch_q <= 4'h0;
        else if (glitch_q != GLITCH_CYC)
            glitch_q <= glitch_q + 4'h1;
    end

    // Secondary oscillator tick
    logic [3:0] div_q;
    logic       tick;
    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            div_q <= 4'h0;
        else if (div_q == 4'(`GDPM_OSC_DIV - 1))
            div_q <= 4'h0;
        else
            div_q <= div_q + 4'h1;
    end
    assign tick = (div_q == 4'h0);

    // Turn-on start and turn-off hard transition
    logic pwm_d1_q, hard_d1_q;
    logic on_start, off_start;
    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pwm_d1_q  <= 1'b0;
            hard_d1_q <= 1'b0;
        end
        else
        begin
            pwm_d1_q  <= pwm_q;
            hard_d1_q <= i_hard_turnoff;
        end
    end
    assign on_start  = pwm_q && !pwm_d1_q;
    assign off_start = i_hard_turnoff && !hard_d1_q;

    gdpm_tmr_if ton_if ();
    gdpm_tmr_if toff_if ();
    assign ton_if.start   = on_start;
    assign ton_if.reached = up_q;
    assign ton_if.tick    = tick;
    assign toff_if.start   = off_start;
    assign toff_if.reached = lo_q;
    assign toff_if.tick    = tick;
    gdpm_gate_timer u_ton (.i_clk(i_ref_clk), .i_rst_n(rst_n), .tmr(ton_if));
    gdpm_gate_timer u_toff (.i_clk(i_ref_clk), .i_rst_n(rst_n), .tmr(toff_if));

    // turn-on timeout masked in test modes
    logic ton_timeout;
    assign ton_timeout = ton_if.ovf && !(i_verification_mode || i_weak_on_mode);

    // sticky flags, set wins over clear
    logic cc_err_q, gate_err_q, ot_q, spi_q;
    logic cc_set, gate_set, ot_set, spi_set;
    assign cc_set   = (glitch_q == GLITCH_CYC);
    assign gate_set = ton_timeout || toff_if.ovf;
    assign ot_set   = (i_temperature > `GDPM_TEMP_THRESH);
    assign spi_set  = i_spi_invalid || (i_parity_check_en && i_spi_parity_bad);
    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cc_err_q   <= 1'b0;
            gate_err_q <= 1'b0;
            ot_q       <= 1'b0;
            spi_q      <= 1'b0;
        end
        else
        begin
            cc_err_q   <= cc_set   || (cc_err_q   && !i_flag_clear[0]);
            gate_err_q <= gate_set || (gate_err_q && !i_flag_clear[1]);
            ot_q       <= ot_set   || (ot_q       && !i_flag_clear[2]);
            spi_q      <= spi_set  || (spi_q      && !i_flag_clear[3]);
        end
    end
    assign o_crossconduction_error_flag = cc_err_q;
    assign o_gate_error_flag            = gate_err_q;
    assign o_overtemperature_flag       = ot_q;
    assign o_spi_error_flag             = spi_q;

    logic on_arm_q, off_arm_q, on_run_q, off_run_q;
    logic [7:0] on_val_q, off_val_q;
    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            on_arm_q  <= 1'b0;
            on_run_q  <= 1'b0;
            on_val_q  <= 8'h00;
        end
        else if (on_arm_q && on_start)
        begin
            on_run_q <= 1'b1;
            on_val_q <= 8'h00;
        end
        else if (on_run_q && (ton_if.stop || ton_if.ovf))
        begin
            on_run_q <= 1'b0;
            on_arm_q <= 1'b0;
            on_val_q <= ton_if.ovf ? `GDPM_CNT_MAX : ton_if.count;
        end
        else if (i_timing_capture_trigger)
            on_arm_q <= 1'b1;
    end
    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            off_arm_q <= 1'b0;
            off_run_q <= 1'b0;
            off_val_q <= 8'h00;
        end
        else if (off_arm_q && off_start)
        begin
            off_run_q <= 1'b1;
            off_val_q <= 8'h00;
        end
        else if (off_run_q && (toff_if.stop || toff_if.ovf))
        begin
            off_run_q <= 1'b0;
            off_arm_q <= 1'b0;
            off_val_q <= toff_if.ovf ? `GDPM_CNT_MAX : toff_if.count;
        end
        else if (i_timing_capture_trigger)
            off_arm_q <= 1'b1;
    end
    assign o_turnon_capture_armed  = on_arm_q;
    assign o_turnoff_capture_armed = off_arm_q;
    assign o_turnon_capture_value  = on_val_q;
    assign o_turnoff_capture_value = off_val_q;

    assign o_undervoltage_notify_out = 1'b0;
    assign o_undervoltage_notify_oe  = i_secondary_uv || !i_digital_supply_ok;

    logic [4:0] blank_q;
    logic       state_q;
    logic       cmd_d1_q;
    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            blank_q <= 5'h00;
            state_q <= 1'b0;
        end
        else if (cmd_q != cmd_d1_q)
            blank_q <= 5'(`GDPM_BLANK_CYC);
        else if (blank_q != 5'h00)
        begin
            blank_q <= blank_q - 5'h01;
            if (blank_q == 5'h01)
                state_q <= sat_q;
        end
    end
    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            cmd_d1_q <= 1'b0;
        else
            cmd_d1_q <= cmd_q;
    end
    assign o_state_report_oe  = i_primary_state_output_enable
                             && i_secondary_state_monitor_enable;
    assign o_state_report_out = state_q;
    assign o_state_report_level_bit = o_state_report_oe ? state_q : 1'b0;

    a_block_cmd: assert property (@(posedge i_ref_clk)
        disable iff (!rst_n) (inhibit && !pwm_q) |=> !pwm_q)
        else $error("gate turned on while inhibited");
    a_dead_hold: assert property (@(posedge i_ref_clk)
        disable iff (!rst_n) $fell(cp_q) |-> inhibit[*8])
        else $error("dead time too short");
    a_cc_err_set: assert property (@(posedge i_ref_clk)
        disable iff (!rst_n) conflict[*3] |=> cc_err_q)
        else $error("conflict did not set error");
    a_glitch_free: assert property (@(posedge i_ref_clk)
        disable iff (!rst_n) $rose(cc_err_q) |-> $past(conflict, 2))
        else $error("error set by glitch");
    a_to_masked: assert property (@(posedge i_ref_clk)
        disable iff (!rst_n) (ton_if.ovf && !toff_if.ovf
        && (i_verification_mode || i_weak_on_mode)) |=> !$rose(gate_err_q))
        else $error("turn-on timeout in test mode");
    a_flag_sticky: assert property (@(posedge i_ref_clk)
        disable iff (!rst_n) (gate_err_q && !i_flag_clear[1]) |=> gate_err_q)
        else $error("gate error cleared itself");
    a_arm_both: assert property (@(posedge i_ref_clk)
        disable iff (!rst_n) (i_timing_capture_trigger && !on_run_q
        && !off_run_q && !on_start && !off_start) |=> on_arm_q && off_arm_q)
        else $error("trigger did not arm captures");
    a_uv_notify: assert property (@(posedge i_ref_clk)
        disable iff (!rst_n) !i_digital_supply_ok |-> o_undervoltage_notify_oe)
        else $error("undervoltage pin not driven low");
    a_state_oe: assert property (@(posedge i_ref_clk)
        disable iff (!rst_n) !i_secondary_state_monitor_enable
        |-> !o_state_report_oe)
        else $error("state pin driven without enable");
endmodule : gdpm_top
`default_nettype wire

// file: bench/gdpm_gate_model.sv
// Purpose: Behavioural gate and comparator model facing the driver output
// Assumes: Driven at the falling clock edge, like the rest of the bench
// Notes:   Gate can be held mid-swing to force timer overflow
`timescale 1ns/100ps
`default_nettype none
module gdpm_gate_model
(
    input  wire logic        i_clk,
    input  wire logic        i_pwm_to_gate,
    input  wire logic [11:0] i_on_delay,
    input  wire logic [11:0] i_off_delay,
    input  wire logic        i_stuck,
    output logic             o_gate_above_upper,
    output logic             o_gate_below_lower,
    output logic             o_hard_turnoff
);
    logic        prev_q;
    logic [11:0] cnt_q;

    initial
    begin
        prev_q = 1'b0;
        cnt_q = 12'h000;
        o_gate_above_upper = 1'b0;
        o_gate_below_lower = 1'b1;
        o_hard_turnoff = 1'b0;
    end

    // Gate leaves both thresholds at every edge, then settles after a delay
    always @(negedge i_clk)
    begin
        prev_q <= i_pwm_to_gate;
        if (i_pwm_to_gate !== prev_q)
        begin
            cnt_q <= 12'h000;
            o_gate_above_upper <= 1'b0;
            o_gate_below_lower <= 1'b0;
            o_hard_turnoff <= ~i_pwm_to_gate;
        end
        else if (!i_stuck && cnt_q != 12'hfff)
        begin
            cnt_q <= cnt_q + 12'h001;
            if (i_pwm_to_gate && cnt_q == i_on_delay)
                o_gate_above_upper <= 1'b1;
            if (!i_pwm_to_gate && cnt_q == i_off_delay)
                o_gate_below_lower <= 1'b1;
        end
    end
endmodule : gdpm_gate_model
`default_nettype wire

// file: bench/gdpm_top_tb.sv
// Purpose: Self-checking bench for the protection monitor
// Assumes: Inputs change at the falling edge; 40 MHz clock
// Notes:   Counterpart and host pins driven here, gate by the model
`timescale 1ns/100ps
`default_nettype none
`include "gdpm_regs.svh"
module gdpm_top_tb;
    logic        clk, rst_n, cmd, cp, vm, wm, trig, spi_inv, spi_par;
    logic        par_en, uv, dig_ok, sat, pen, sen, stuck, hi, lo, hard;
    logic [3:0]  cfg;
    logic [4:0]  clr_v;
    logic [7:0]  temp, onv, offv;
    logic [11:0] on_dly;
    logic        pwm, ccs, ccf, gef, otf, spf, ona, offa;
    logic        uvo, uvoe, sro, sroe, srl;
    logic [2:0]  watch;
    int          n_fail, num_checks;

    assign watch = {gef, offa, ona};

    always #12.5 clk = ~clk;

    gdpm_top uut
    (
        .i_ref_clk(clk), .i_resetn(rst_n), .i_pwm_command_pin(cmd),
        .i_counterpart_pwm_input(cp), .i_dead_time_config(cfg),
        .i_gate_above_upper(hi), .i_gate_below_lower(lo),
        .i_hard_turnoff(hard), .i_verification_mode(vm),
        .i_weak_on_mode(wm), .i_timing_capture_trigger(trig),
        .i_temperature(temp), .i_spi_invalid(spi_inv),
        .i_spi_parity_bad(spi_par), .i_parity_check_en(par_en),
        .i_secondary_uv(uv), .i_digital_supply_ok(dig_ok),
        .i_saturation_sense_pin(sat),
        .i_primary_state_output_enable(pen),
        .i_secondary_state_monitor_enable(sen), .i_flag_clear(clr_v),
        .o_pwm_to_gate(pwm), .o_crossconduction_status_bit(ccs),
        .o_crossconduction_error_flag(ccf), .o_gate_error_flag(gef),
        .o_overtemperature_flag(otf), .o_spi_error_flag(spf),
        .o_turnon_capture_armed(ona), .o_turnoff_capture_armed(offa),
        .o_turnon_capture_value(onv), .o_turnoff_capture_value(offv),
        .o_undervoltage_notify_out(uvo), .o_undervoltage_notify_oe(uvoe),
        .o_state_report_out(sro), .o_state_report_oe(sroe),
        .o_state_report_level_bit(srl)
    );

    gdpm_gate_model gate
    (
        .i_clk(clk), .i_pwm_to_gate(pwm), .i_on_delay(on_dly),
        .i_off_delay(12'd40), .i_stuck(stuck), .o_gate_above_upper(hi),
        .o_gate_below_lower(lo), .o_hard_turnoff(hard)
    );

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [7:0] got,
                       input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    // Bounded wait on one watched output; running out ends the run
    task automatic wait_lvl(input string nm, input int sel, input logic lvl,
                            input int lim);
        int i;
        i = 0;
        while (watch[sel] !== lvl && i < lim)
        begin
            cyc(1);
            i++;
        end
        chk(nm, {7'h00, watch[sel]}, {7'h00, lvl});
        if (watch[sel] !== lvl)
            print_verdict();
    endtask : wait_lvl

    task automatic clr(input logic [4:0] m);
        clr_v = m;
        cyc(1);
        clr_v = 5'h00;
        cyc(2);
    endtask : clr

    function automatic logic [7:0] inr(input logic [7:0] v, lo_b, hi_b);
        return (v >= lo_b && v <= hi_b) ? 8'h01 : 8'h00;
    endfunction : inr

    initial
    begin
        repeat (100000) @(posedge clk);
        n_fail++;
        print_verdict();
    end

    initial
    begin
        {clk, cmd, cp, vm, wm, trig, spi_inv, spi_par, uv, sat, stuck} = '0;
        {rst_n, pen, sen} = '0;
        {par_en, dig_ok} = 2'b11;
        {cfg, clr_v, temp, on_dly} = {4'h0, 5'h00, 8'h20, 12'd40};
        n_fail = 0;
        num_checks = 0;
        cyc(3);
        rst_n = 1'b1;
        cyc(4);
        chk("rst_flags", {4'h0, ccf, gef, otf, spf}, 8'h00);
        chk("rst_armed", {6'h00, ona, offa}, 8'h00);
        // Held conflict: command blocked, status shown, flag sticky
        cp = 1'b1;
        cyc(6);
        cmd = 1'b1;
        cyc(12);
        chk("cc_status", {7'h00, ccs}, 8'h01);
        chk("cc_pwm", {7'h00, pwm}, 8'h00);
        chk("cc_flag", {7'h00, ccf}, 8'h01);
        cp = 1'b0;
        cyc(40);
        chk("cc_refused", {7'h00, pwm}, 8'h00);
        cmd = 1'b0;
        cyc(6);
        chk("cc_sticky", {7'h00, ccf}, 8'h01);
        clr(5'h01);
        chk("cc_clear", {7'h00, ccf}, 8'h00);
        cp = 1'b1;
        cyc(6);
        cmd = 1'b1;
        cyc(1);
        cmd = 1'b0;
        cyc(10);
        chk("cc_glitch", {7'h00, ccf}, 8'h00);
        cp = 1'b0;
        $display("test guard done");
        // host keeps spacing; guard blocks the command and sets the error flag when too short
        for (int k = 0; k < 2; k++)
        begin
            cfg = (k == 0) ? 4'h0 : 4'h2;
            cp = 1'b1;
            cyc(6);
            cp = 1'b0;
            cyc(`GDPM_DEAD_MIN_CYC + `GDPM_DEAD_STEP_CYC + 2);
            cmd = 1'b1;
            cyc(10);
            chk("dead_pwm", {7'h00, pwm}, (k == 0) ? 8'h01 : 8'h00);
            chk("dead_flag", {7'h00, ccf}, (k == 0) ? 8'h00 : 8'h01);
            cmd = 1'b0;
            cyc(60);
            clr(5'h01);
        end
        chk("gate_quiet", {7'h00, gef}, 8'h00);
        $display("test dead time done");
        trig = 1'b1;
        cyc(1);
        trig = 1'b0;
        cyc(2);
        chk("arm_both", {6'h00, ona, offa}, 8'h03);
        cmd = 1'b1;
        wait_lvl("on_cap", 0, 1'b0, 400);
        chk("on_val", inr(onv, 8'd8, 8'd13), 8'h01);
        cmd = 1'b0;
        wait_lvl("off_cap", 1, 1'b0, 400);
        chk("off_val", inr(offv, 8'd8, 8'd13), 8'h01);
        trig = 1'b1;
        cyc(1);
        trig = 1'b0;
        stuck = 1'b1;
        cmd = 1'b1;
        wait_lvl("on_ovf", 2, 1'b1, 1300);
        cyc(4);
        chk("on_ovf_val", onv, 8'hff);
        clr(5'h02);
        cmd = 1'b0;
        wait_lvl("off_ovf", 2, 1'b1, 1300);
        cyc(4);
        chk("off_ovf_val", offv, 8'hff);
        stuck = 1'b0;
        cyc(60);
        clr(5'h02);
        for (int k = 0; k < 2; k++)
        begin
            vm = (k == 0);
            wm = (k == 1);
            stuck = 1'b1;
            cmd = 1'b1;
            cyc(1200);
            chk("mode_on", {7'h00, gef}, 8'h00);
            cmd = 1'b0;
            wait_lvl("mode_off", 2, 1'b1, 1300);
            stuck = 1'b0;
            cyc(60);
            clr(5'h02);
        end
        {vm, wm} = 2'b00;
        $display("test gate monitor done");
        temp = `GDPM_TEMP_THRESH;
        cyc(4);
        chk("ot_at", {7'h00, otf}, 8'h00);
        temp = `GDPM_TEMP_THRESH + 8'h01;
        cyc(4);
        temp = 8'h20;
        cyc(4);
        chk("ot_above", {7'h00, otf}, 8'h01);
        clr(5'h04);
        chk("ot_clear", {7'h00, otf}, 8'h00);
        spi_inv = 1'b1;
        cyc(1);
        spi_inv = 1'b0;
        cyc(3);
        chk("spi_inv", {7'h00, spf}, 8'h01);
        clr(5'h08);
        for (int k = 0; k < 2; k++)
        begin
            par_en = k[0];
            spi_par = 1'b1;
            cyc(1);
            spi_par = 1'b0;
            cyc(3);
            chk("spi_par", {7'h00, spf}, {7'h00, k[0]});
            clr(5'h08);
        end
        for (int k = 0; k < 4; k++)
        begin
            uv = k[0];
            dig_ok = ~k[1];
            cyc(4);
            chk("uv_oe", {7'h00, uvoe}, {7'h00, k[0] | k[1]});
            chk("uv_out", {7'h00, uvo}, 8'h00);
        end
        {uv, dig_ok} = 2'b01;
        $display("test flags done");
        // Saturation clamping assumed off by the host here
        {pen, sen, sat} = 3'b111;
        cmd = 1'b1;
        cyc(`GDPM_BLANK_CYC + 14);
        chk("st_out", {5'h00, sro, sroe, srl}, 8'h07);
        for (int k = 0; k < 3; k++)
        begin
            pen = k[0];
            sen = k[1];
            cyc(3);
            chk("st_off", {6'h00, sroe, srl}, 8'h00);
        end
        {pen, sen} = 2'b11;
        sat = 1'b0;
        cmd = 1'b0;
        cyc(`GDPM_BLANK_CYC + 14);
        chk("st_low", {5'h00, sro, sroe, srl}, 8'h02);
        $display("test state report done");
        print_verdict();
    end
endmodule : gdpm_top_tb
`default_nettype wire
